// >>> dv/rsoc_line_model.sv
`timescale 1ns/1ps
`include "rsoc_params.svh"
module rsoc_line_model #(
    parameter int FRAME_LEN = 1200
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic strobe,
    output logic fs,
    output logic [7:0] data,
    output logic [13:0] idx
);
    // one byte a cycle and a short frame keep the run small
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe <= 1'b0;
            // first strobed byte after release is frame byte 0
            idx <= 14'(FRAME_LEN - 1);
        end else begin
            strobe <= 1'b1;
            idx <= (idx == 14'(FRAME_LEN - 1)) ? 14'h0000 : idx + 14'h0001;
        end
    end
    assign fs = strobe && (idx == 14'h0000);
    // other bytes churn so a stale slot never looks right
    assign data = (idx == `RSOC_E1_IDX) ? 8'hA5 : (idx == `RSOC_F1_IDX) ? 8'h3C : ~idx[7:0];
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
`include "rsoc_params.svh"
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic strobe, fs, ow_ssf, usr_ssf, usr_clk;
    logic trail_fail = 1'b0;
    logic [7:0] ldata, last_e1, last_f1;
    logic [13:0] idx, idx_q;
    rsoc_pkg::rsoc_line_type line_out;
    rsoc_pkg::rsoc_client_type ow_ch, usr_ch;
    logic ow_d = 1'b1, ow_c = 1'b0, ow_f = 1'b0, usr_bit = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int err_count = 0, samples_checked = 0, e1_cnt = 0, n;

    always #5 aclk = ~aclk;

    rsoc_line_model i_rsoc_line_model (.aclk, .aresetn, .strobe, .fs, .data(ldata), .idx);

    rsoc_adapt i_rsoc_adapt (.aclk, .aresetn, .ce(1'b1), .line_timing_clock(strobe),
        .line_frame_start(fs), .section_access_data(ldata), .trail_signal_fail_in(trail_fail),
        .section_access_data_out(line_out), .ow_src_data(ow_d), .ow_src_clk(ow_c),
        .ow_src_fs(ow_f), .orderwire_channel(ow_ch), .client_server_fail_out(ow_ssf),
        .usr_src_data(usr_bit), .usr_src_clk(usr_clk), .user_data_channel(usr_ch),
        .user_server_fail_out(usr_ssf), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tmo(input int cnt, input int lim);
        if (cnt >= lim) begin
            err_count++;
            wrap_up();
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int k;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 50 && (k == 0 || s_axi_awvalid || s_axi_wvalid); k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        tmo(k, 50);
        for (k = 0; k < 50 && s_axi_bvalid !== 1'b1; k++) @(posedge aclk);
        tmo(k, 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 50 && !(s_axi_arvalid && s_axi_arready); k++) @(posedge aclk);
        tmo(k, 50);
        s_axi_arvalid <= 1'b0;
        for (k = 0; k < 50 && s_axi_rvalid !== 1'b1; k++) @(posedge aclk);
        tmo(k, 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // client bits MSB first, four cycles a bit: far faster than one octet a frame
    task automatic send_oct(input int cnt, input logic [7:0] b);
        int i;
        for (i = 0; i < cnt * 8; i++) begin
            ow_d <= b[7 - i % 8];
            ow_f <= (i % 8 == 0);
            ow_c <= 1'b0;
            repeat (2) @(posedge aclk);
            ow_c <= 1'b1;
            repeat (2) @(posedge aclk);
        end
        ow_c <= 1'b0;
    endtask

    // sample each bit mid-period, 781 + 781 = one 1562-cycle bit
    task automatic ser_chk(input logic usr, input logic [7:0] exp);
        int k;
        int i;
        logic [7:0] got;
        k = 0;
        while (k < 30000 && (usr ? usr_ch.fs : ow_ch.fs) !== 1'b0) begin
            @(posedge aclk);
            k++;
        end
        while (k < 30000 && (usr ? usr_ch.fs : ow_ch.fs) !== 1'b1) begin
            @(posedge aclk);
            k++;
        end
        tmo(k, 30000);
        for (i = 7; i >= 0; i--) begin
            repeat (781) @(posedge aclk);
            got[i] = usr ? usr_ch.data : ow_ch.data;
            repeat (781) @(posedge aclk);
        end
        check(32'(got), 32'(exp));
    endtask

    always @(posedge aclk) begin
        idx_q <= idx;
        if (line_out.valid === 1'b1) begin
            if (idx_q == `RSOC_E1_IDX) begin
                last_e1 <= line_out.data;
                e1_cnt <= e1_cnt + 1;
            end else if (idx_q == `RSOC_F1_IDX) begin
                last_f1 <= line_out.data;
            end else begin
                check(32'(idx_q), 32'(`RSOC_F1_IDX));
            end
        end
    end

    initial begin
        repeat (6) @(posedge aclk);
        check(32'({ow_ch.data, usr_ch.data, line_out.valid, s_axi_bvalid}), 32'h0000_000C);
        aresetn <= 1'b1;
        repeat (1300) @(posedge aclk);
        axi_rd(`RSOC_ADDR_STAT, rd, rsp);
        check(rd & 32'h0000_0017, 32'h0000_0010);
        check(32'(rsp), 32'(`RSOC_RESP_OK));
        send_oct(12, 8'h5A);
        // no slot yet: store full, overrun flagged, no negative justification yet
        axi_rd(`RSOC_ADDR_STAT, rd, rsp);
        check(rd & 32'h0000_00A7, 32'h0000_0084);
        // long wait so the user source has shifted a whole octet of ones
        repeat (12500) @(posedge aclk);
        axi_rd(`RSOC_ADDR_STAT, rd, rsp);
        check(rd & 32'h0000_00A0, 32'h0000_00A0);
        check(32'(last_e1), 32'h0000_005A);
        check(32'(last_f1), 32'h0000_00FF);
        usr_bit <= 1'b0;
        axi_wr(`RSOC_ADDR_STAT, 32'h0000_0080, rsp);
        axi_rd(`RSOC_ADDR_STAT, rd, rsp);
        check(rd & 32'h0000_0080, 32'h0000_0000);
        axi_rd(4'h8, rd, rsp);
        check(32'(rsp), 32'(`RSOC_RESP_ERR));
        axi_wr(4'hC, 32'h0000_0001, rsp);
        check(32'(rsp), 32'(`RSOC_RESP_ERR));
        ser_chk(1'b0, 8'hA5);
        ser_chk(1'b1, 8'h3C);
        check(32'(last_f1), 32'h0000_0000);
        axi_wr(`RSOC_ADDR_CTRL, 32'h0000_0001, rsp);
        axi_rd(`RSOC_ADDR_CTRL, rd, rsp);
        check(rd & 32'h0000_0001, 32'h0000_0001);
        n = e1_cnt;
        repeat (2500) @(posedge aclk);
        check(32'(e1_cnt), 32'(n));
        check(32'(last_f1), 32'h0000_005A);
        trail_fail <= 1'b1;
        repeat (3) @(posedge aclk);
        check(32'({ow_ssf, usr_ssf, ow_ch.data, usr_ch.data}), 32'h0000_000F);
        trail_fail <= 1'b0;
        for (n = 0; n < 200 && {ow_ssf, usr_ssf} !== 2'b00; n++) @(posedge aclk);
        tmo(n, 200);
        axi_rd(`RSOC_ADDR_STAT, rd, rsp);
        check(rd & 32'h0000_0040, 32'h0000_0040);
        wrap_up();
    end
endmodule

// >>> rtl/rsoc_adapt.sv
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "rsoc_params.svh"
module rsoc_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);
    logic [W-1:0] mem_q [D];
    logic [$clog2(D)-1:0] wp_q, rp_q;
    logic [$clog2(D):0] cnt_q;
    logic push, pop;
    assign in_ready = (cnt_q != D[$clog2(D):0]);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    assign level = cnt_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            if (push) begin
                mem_q[wp_q] <= in_data;
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + {{$clog2(D){1'b0}}, push} - {{$clog2(D){1'b0}}, pop};
        end
    end
endmodule

module rsoc_adapt (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic line_timing_clock,
    input wire logic line_frame_start,
    input wire logic [7:0] section_access_data,
    input wire logic trail_signal_fail_in,
    output rsoc_pkg::rsoc_line_type section_access_data_out,
    input wire logic ow_src_data,
    input wire logic ow_src_clk,
    input wire logic ow_src_fs,
    output rsoc_pkg::rsoc_client_type orderwire_channel,
    output logic client_server_fail_out,
    input wire logic usr_src_data,
    output logic usr_src_clk,
    output rsoc_pkg::rsoc_client_type user_data_channel,
    output logic user_server_fail_out,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int BC = `RSOC_BIT_CYC;
    logic [`RSOC_COL_W-1:0] col_q, col_d, col_now;
    logic slot_e1, slot_f1, ow_slot, usr_slot;
    logic [10:0] div_q, div_d;
    logic tick;
    logic [2:0] bit_q, bit_d;
    logic ctrl_f1_q, ctrl_f1_d;
    logic [3:0] sticky_q, sticky_d;
    // line position: strobe with frame start is byte 0
    assign col_now = line_frame_start ? '0 : col_q;
    assign slot_e1 = line_timing_clock && col_now == `RSOC_E1_IDX;
    assign slot_f1 = line_timing_clock && col_now == `RSOC_F1_IDX;
    assign ow_slot = ctrl_f1_q ? slot_f1 : slot_e1;
    assign usr_slot = slot_f1 && !ctrl_f1_q;
    assign tick = div_q == 11'(BC - 1);
    always_comb begin
        col_d = col_q;
        if (line_timing_clock) begin
            col_d = col_now + 1'b1;
        end
        div_d = tick ? '0 : div_q + 1'b1;
        bit_d = tick ? bit_q + 1'b1 : bit_q;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            col_q <= '0;
            div_q <= '0;
            bit_q <= '0;
        end else if (ce) begin
            col_q <= col_d;
            div_q <= div_d;
            bit_q <= bit_d;
        end
    end

    // orderwire source: octets assembled on the client's own clock edges
    logic ck_prev_q, ck_prev_d, ow_edge;
    logic [7:0] ow_sh_q, ow_sh_d;
    logic [2:0] ow_cnt_q, ow_cnt_d;
    logic ow_pend_q, ow_pend_d, f_ready, f_valid, f_pop;
    logic [7:0] f_data, out_hold_q, out_hold_d;
    logic [2:0] f_lvl;
    logic reread_q, reread_d;
    rsoc_pkg::rsoc_just_type just;
    assign ow_edge = ow_src_clk && !ck_prev_q;
    always_comb begin
        ck_prev_d = ow_src_clk;
        ow_sh_d = ow_sh_q;
        ow_cnt_d = ow_cnt_q;
        ow_pend_d = ow_pend_q && !f_ready;
        // a pending octet stalls; one more edge before release is an overrun
        if (ow_edge) begin
            ow_sh_d = {ow_sh_q[6:0], ow_src_data};
            ow_cnt_d = ow_src_fs ? 3'h1 : ow_cnt_q + 1'b1;
            if (ow_cnt_d == 3'h0) begin
                ow_pend_d = 1'b1;
            end
        end
    end
    rsoc_fifo #(.W(8), .D(`RSOC_FIFO_D)) u_slip (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .in_valid(ow_pend_q),
        .in_ready(f_ready),
        .in_data(ow_sh_q),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data),
        .level(f_lvl)
    );
    always_comb begin
        just = rsoc_pkg::JUST_NONE;
        if (f_lvl == `RSOC_LVL_LOW) begin
            just = rsoc_pkg::JUST_POS;
        end else if (f_lvl == `RSOC_LVL_HIGH && !reread_q) begin
            just = rsoc_pkg::JUST_NEG;
        end
        f_pop = 1'b0;
        reread_d = reread_q;
        out_hold_d = out_hold_q;
        if (ow_slot) begin
            case (just)
                rsoc_pkg::JUST_POS: begin
                    out_hold_d = out_hold_q;
                end
                rsoc_pkg::JUST_NEG: begin
                    out_hold_d = f_data;
                    reread_d = 1'b1;
                end
                default: begin
                    out_hold_d = f_data;
                    f_pop = f_valid;
                    reread_d = 1'b0;
                end
            endcase
        end
    end

    // user source: we clock the client, sample on each tick
    logic [7:0] us_sh_q, us_sh_d, us_byte_q, us_byte_d;
    always_comb begin
        us_sh_d = tick ? {us_sh_q[6:0], usr_src_data} : us_sh_q;
        us_byte_d = (tick && bit_q == 3'h7) ? us_sh_d : us_byte_q;
    end
    assign usr_src_clk = div_q < 11'(BC / 2);

    rsoc_pkg::rsoc_line_type lo_d, lo_q;
    always_comb begin
        lo_d = '0;
        if (ow_slot) begin
            lo_d = '{valid: 1'b1, data: out_hold_d};
        end else if (usr_slot) begin
            lo_d = '{valid: 1'b1, data: us_byte_q};
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ck_prev_q <= 1'b0;
            ow_sh_q <= '0;
            ow_cnt_q <= '0;
            ow_pend_q <= 1'b0;
            out_hold_q <= '0;
            reread_q <= 1'b0;
            us_sh_q <= '0;
            us_byte_q <= '0;
            lo_q <= '0;
        end else if (ce) begin
            ck_prev_q <= ck_prev_d;
            ow_sh_q <= ow_sh_d;
            ow_cnt_q <= ow_cnt_d;
            ow_pend_q <= ow_pend_d;
            out_hold_q <= out_hold_d;
            reread_q <= reread_d;
            us_sh_q <= us_sh_d;
            us_byte_q <= us_byte_d;
            lo_q <= lo_d;
        end
    end
    assign section_access_data_out = lo_q;

    // sinks: index 0 orderwire (E1 or F1), index 1 user (F1)
    logic [1:0] sk_slot;
    logic [7:0] st_q [2];
    logic [7:0] st_d [2];
    logic [7:0] ser_q [2];
    logic [7:0] ser_d [2];
    rsoc_pkg::rsoc_client_type co_q [2];
    rsoc_pkg::rsoc_client_type co_d [2];
    assign sk_slot = {slot_f1, ow_slot};
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sink
            always_comb begin
                st_d[g] = sk_slot[g] ? section_access_data : st_q[g];
                ser_d[g] = ser_q[g];
                if (tick) begin
                    ser_d[g] = (bit_q == 3'h7) ? st_q[g] : {ser_q[g][6:0], 1'b0};
                end
                co_d[g].fail = trail_signal_fail_in;
                co_d[g].data = trail_signal_fail_in | ser_d[g][7];
                co_d[g].clk = div_d < 11'(BC / 2);
                co_d[g].fs = bit_d == 3'h0;
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    st_q[g] <= 8'hff;
                    ser_q[g] <= 8'hff;
                    co_q[g] <= '{data: 1'b1, clk: 1'b0, fs: 1'b0, fail: 1'b0};
                end else if (ce) begin
                    st_q[g] <= st_d[g];
                    ser_q[g] <= ser_d[g];
                    co_q[g] <= co_d[g];
                end
            end
        end
    endgenerate
    assign orderwire_channel = co_q[0];
    assign user_data_channel = co_q[1];
    assign client_server_fail_out = co_q[0].fail;
    assign user_server_fail_out = co_q[1].fail;

    // axi4-lite slave; answers one cycle after both halves are held
    logic bv_q, bv_d, rv_q, rv_d, wr_go, rd_go;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic [31:0] rd_q, rd_d;
    logic [3:0] ev;
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bv_q;
    assign rd_go = s_axi_arvalid && !rv_q;
    assign ev = {ow_edge && ow_pend_q && !f_ready, trail_signal_fail_in,
                 ow_slot && just == rsoc_pkg::JUST_NEG, ow_slot && just == rsoc_pkg::JUST_POS};
    always_comb begin
        ctrl_f1_d = ctrl_f1_q;
        sticky_d = sticky_q;
        bv_d = bv_q && !s_axi_bready;
        br_d = br_q;
        rv_d = rv_q && !s_axi_rready;
        rr_d = rr_q;
        rd_d = rd_q;
        if (wr_go) begin
            bv_d = 1'b1;
            br_d = `RSOC_RESP_OK;
            if (s_axi_awaddr == `RSOC_ADDR_CTRL && s_axi_wstrb[0]) begin
                ctrl_f1_d = s_axi_wdata[0];
            end else if (s_axi_awaddr == `RSOC_ADDR_STAT && s_axi_wstrb[0]) begin
                sticky_d = sticky_q & ~s_axi_wdata[`RSOC_ST_OVR:`RSOC_ST_POS];
            end else if (s_axi_awaddr != `RSOC_ADDR_STAT && s_axi_awaddr != `RSOC_ADDR_CTRL) begin
                br_d = `RSOC_RESP_ERR;
            end
        end
        sticky_d = sticky_d | ev; // set beats clear
        if (rd_go) begin
            rv_d = 1'b1;
            rr_d = `RSOC_RESP_OK;
            rd_d = '0;
            if (s_axi_araddr == `RSOC_ADDR_CTRL) begin
                rd_d[0] = ctrl_f1_q;
            end else if (s_axi_araddr == `RSOC_ADDR_STAT) begin
                rd_d[2:0] = f_lvl;
                rd_d[`RSOC_ST_OVR:`RSOC_ST_POS] = sticky_q;
            end else begin
                rr_d = `RSOC_RESP_ERR;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_f1_q <= `RSOC_CTRL_RST;
            sticky_q <= '0;
            bv_q <= 1'b0;
            br_q <= '0;
            rv_q <= 1'b0;
            rr_q <= '0;
            rd_q <= '0;
        end else if (ce) begin
            ctrl_f1_q <= ctrl_f1_d;
            sticky_q <= sticky_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rr_q <= rr_d;
            rd_q <= rd_d;
        end
    end
    assign s_axi_awready = wr_go && ce;
    assign s_axi_wready = wr_go && ce;
    assign s_axi_arready = rd_go && ce;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rresp = rr_q;
    assign s_axi_rdata = rd_q;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);
    chk_ow_slot_out: assert property (ow_slot |=> lo_q.valid && lo_q.data == $past(out_hold_d))
        else $error("orderwire slot not driven");
    chk_one_read: assert property (f_pop |-> ow_slot)
        else $error("slip read outside the slot");
    chk_pos_skip: assert property (ow_slot && just == rsoc_pkg::JUST_POS |=> lo_q.data == $past(out_hold_q))
        else $error("positive justification read an octet");
    chk_neg_reread: assert property (ow_slot && just == rsoc_pkg::JUST_NEG |-> !f_pop ##1 reread_q)
        else $error("negative justification popped");
    chk_no_overflow: assert property (f_lvl <= 3'(`RSOC_FIFO_D))
        else $error("slip store overfilled");
    chk_sink_latch: assert property (sk_slot[0] |=> st_q[0] == $past(section_access_data))
        else $error("sink octet not latched");
    chk_bit_rate: assert property (tick |=> !tick [*8])
        else $error("bit tick too fast");
    chk_fail_ones: assert property (trail_signal_fail_in |=> orderwire_channel.data && client_server_fail_out)
        else $error("orderwire sink not all ones");
    chk_user_f1: assert property (lo_q.valid && !$past(ow_slot) |-> $past(slot_f1))
        else $error("user byte outside F1");
    chk_user_fail: assert property (trail_signal_fail_in [*2] |=> user_data_channel.data && user_server_fail_out)
        else $error("user sink not all ones");
    chk_level_just: assert property (ow_slot && f_lvl == 3'h0 |-> just == rsoc_pkg::JUST_POS)
        else $error("empty store not skipped");
    cov_pos: cover property (ow_slot && just == rsoc_pkg::JUST_POS);
    cov_neg: cover property (ow_slot && just == rsoc_pkg::JUST_NEG);
    cov_fail_clear: cover property (trail_signal_fail_in ##1 !trail_signal_fail_in);
endmodule

// >>> rtl/rsoc_params.svh
`ifndef RSOC_PARAMS_SVH
`define RSOC_PARAMS_SVH
`define RSOC_CLK_NS 10
`define RSOC_BIT_NS 15625
`define RSOC_BIT_CYC (`RSOC_BIT_NS / `RSOC_CLK_NS)
`define RSOC_COL_W 14
`define RSOC_E1_IDX 14'h0469
`define RSOC_F1_IDX 14'h0471
`define RSOC_FIFO_D 4
`define RSOC_LVL_LOW 3'h0
`define RSOC_LVL_HIGH 3'h4
`define RSOC_ADDR_CTRL 4'h0
`define RSOC_ADDR_STAT 4'h4
`define RSOC_CTRL_RST 1'h0
`define RSOC_ST_POS 4
`define RSOC_ST_NEG 5
`define RSOC_ST_SSF 6
`define RSOC_ST_OVR 7
`define RSOC_RESP_OK 2'h0
`define RSOC_RESP_ERR 2'h2
`endif

// >>> rtl/rsoc_pkg.sv
package rsoc_pkg;
    typedef enum logic [1:0] {
        JUST_NONE = 2'b00,
        JUST_POS = 2'b01,
        JUST_NEG = 2'b10
    } rsoc_just_type;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rsoc_line_type;
    typedef struct packed {
        logic data;
        logic clk;
        logic fs;
        logic fail;
    } rsoc_client_type;
endpackage
